// ===== hw/aoi_params.svh
// Constants for the four-channel analog output process image and register bank.
// Assumes inclusion by bare name from the register bank and the bench.
`ifndef AOI_PARAMS_SVH
`define AOI_PARAMS_SVH
`define AOI_RAW_CODE      6'h05
`define AOI_DIAG          6'h06
`define AOI_CMD           6'h07
`define AOI_TYPE_CODE     6'h08
`define AOI_FW_VER        6'h09
`define AOI_SHIFT_LAYOUT  6'h0a
`define AOI_CHAN_COUNT    6'h0b
`define AOI_MIN_LEN       6'h0c
`define AOI_DATA_STRUCT   6'h0d
`define AOI_ALIGN         6'h0f
`define AOI_HW_VER        6'h10
`define AOI_HW_OFS        6'h11
`define AOI_HW_GAIN       6'h12
`define AOI_F_OFS         6'h13
`define AOI_F_GAIN        6'h14
`define AOI_F_PON         6'h15
`define AOI_UNLOCK        6'h1f
`define AOI_FEATURE       6'h20
`define AOI_U_OFS         6'h21
`define AOI_U_GAIN        6'h22
`define AOI_U_PON         6'h23
`define AOI_UNLOCK_KEY    16'h1235
`define AOI_RST_LAYOUT    16'h0218
`define AOI_RST_CHANS     16'h0218
`define AOI_RST_MINLEN    16'h9800
`define AOI_RST_STRUCT    16'h0000
`define AOI_RST_F_GAIN    16'h0020
`define AOI_RST_FEATURE   16'h0006
`define AOI_RST_U_GAIN    16'h0100
`define AOI_RST_ZERO      16'h0000
`define AOI_DAC_BITS      12
`endif

// ===== hw/aoi_pkg.sv
// Types shared by the analog output process image block.
// Assumes the parameter header is on the include path.
package aoi_pkg;
    typedef logic [15:0] aoi_word_t;
    typedef logic [5:0]  aoi_addr_t;
    typedef enum logic [1:0] {
        AOI_MAP_PLAIN,
        AOI_MAP_FULL_PACKED,
        AOI_MAP_FULL_ALIGNED
    } aoi_map_t;
endpackage

// ===== hw/aoi_regs.sv
// Process image packer and per-channel parameter register bank.
// Assumes coupler-side signals are synchronous to clock; register port is word-wide.
`timescale 1ns/1ns
`include "aoi_params.svh"

// Notes on behaviour
// - Every channel owns a full copy of the parameter register bank.
// - Value low byte holds the least significant part, high byte the most.
// - Byte-order option swaps the two value bytes of each channel, across w0/w1 for a packed even channel.
// - Full mapping adds a control byte out and a status byte back per channel.
// - Plain mapping puts four channel values in words 0 to 3.
// - Full aligned mapping uses two words per channel, eight words in total.
// - Full packed mapping packs two channels into three words, six in total.
// - Raw converter code register shows the 12-bit code sent to the converter.
// - Type and system registers are fixed; writes to them are ignored.
// - Firmware version reads as two ASCII characters, major then minor.
// - Shift register layout register is read-only.
// - Logical channel count register is read-only.
// - Minimum transfer length register reads its fixed value with MSB set.
// - Data structure register reads a fixed layout code.
// - Alignment register is readable and writable volatile storage.
// - Manufacturer parameters are nonvolatile and controller-modifiable.
// - Manufacturer parameter writes are refused unless unlocked first.
// - Diagnostic and command registers are read-only zero.
// - Defaults: factory gain 0x0020, features 0x0006, user gain 0x0100.
// - Terminal type code is fixed and read-only.
// - Only code word 0x1235 lifts write protection.
// - Unlock register reads the code word when unlocked, else zero.
module aoi_regs
    import aoi_pkg::*;
#(
    parameter int        CHANNELS  = 4,                  // Number of output channels.
    parameter aoi_word_t TYPE_CODE = 16'h0abc,           // Arbitrary terminal type value.
    parameter aoi_word_t FW_VER    = 16'h3141            // ASCII major then minor.
) (
    input  wire logic        clock,                      // System clock, 10 MHz.
    input  wire logic        rstn,                       // Asynchronous reset, active low.
    input  wire logic        map_full,                   // Map control and status bytes.
    input  wire logic        map_aligned,                // Word-align each channel.
    input  wire logic        big_endian,                 // Swap the two value bytes of each channel.
    input  wire logic [15:0] out_image [0:7],            // Output image from the coupler.
    input  wire logic        out_valid,                  // One-cycle strobe: out_image is new.
    output logic      [15:0] in_image [0:7],             // Input image to the coupler.
    output logic      [15:0] chan_value [0:3],           // Latched value per channel.
    output logic      [7:0]  channel_control_byte [0:3], // Latched control byte per channel.
    input  wire logic [7:0]  channel_status_byte [0:3],  // Status byte per channel.
    output logic      [11:0] dac_code [0:3],             // Code sent to each converter.
    input  wire logic [1:0]  reg_chan,                   // Register channel select.
    input  wire aoi_addr_t   reg_addr,                   // Register number.
    input  wire logic        reg_wr,                     // One-cycle write strobe.
    input  wire logic        reg_rd,                     // One-cycle read strobe.
    input  wire aoi_word_t   reg_wdata,                  // Write data.
    output aoi_word_t        reg_rdata,                  // Read data, registered.
    output logic             reg_ack                     // Read or write done, one cycle.
);

    // The image tables are sized for four channels only.
    generate
        if (CHANNELS != 4) begin : g_chan_check
            $error("aoi_regs supports exactly four channels");
        end
    endgenerate

    aoi_map_t  map_mode;
    aoi_word_t align_r      [0:3];
    aoi_word_t hw_ver_r     [0:3];
    aoi_word_t hw_ofs_r     [0:3];
    aoi_word_t hw_gain_r    [0:3];
    aoi_word_t f_ofs_r      [0:3];
    aoi_word_t f_gain_r     [0:3];
    aoi_word_t f_pon_r      [0:3];
    aoi_word_t unlock_r     [0:3];
    aoi_word_t feature_r    [0:3];
    aoi_word_t u_ofs_r      [0:3];
    aoi_word_t u_gain_r     [0:3];
    aoi_word_t u_pon_r      [0:3];
    logic      unlocked     [0:3];
    aoi_word_t rdata_nxt;
    logic      wr_param;

    // Mode decode from the coupler's mapping straps.
    always_comb begin
        if (!map_full) begin
            map_mode = AOI_MAP_PLAIN;
        end else if (map_aligned) begin
            map_mode = AOI_MAP_FULL_ALIGNED;
        end else begin
            map_mode = AOI_MAP_FULL_PACKED;
        end
    end

    // Byte order of a value word: low byte is least significant unless swapped.
    function automatic aoi_word_t ord(input aoi_word_t v, input logic be);
        ord = be ? {v[7:0], v[15:8]} : v;
    endfunction

    // Unpack the output image when the coupler strobes it in.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++) begin
                chan_value[i] <= 16'h0000;
                channel_control_byte[i] <= 8'h00;
            end
        end else if (out_valid) begin
            for (int i = 0; i < 4; i++) begin
                case (map_mode)
                    AOI_MAP_PLAIN: begin
                        chan_value[i] <= ord(out_image[i], big_endian);
                        channel_control_byte[i] <= 8'h00;
                    end
                    AOI_MAP_FULL_ALIGNED: begin
                        channel_control_byte[i] <= out_image[2*i][7:0];
                        chan_value[i] <= ord(out_image[2*i+1], big_endian);
                    end
                    default: begin
                        // Packed: even channel CB low of w0, value straddles w0/w1.
                        if (i[0] == 1'b0) begin
                            channel_control_byte[i] <= out_image[3*(i/2)][7:0];
                            chan_value[i] <= big_endian ?
                                {out_image[3*(i/2)][15:8], out_image[3*(i/2)+1][7:0]} :
                                {out_image[3*(i/2)+1][7:0], out_image[3*(i/2)][15:8]};
                        end else begin
                            channel_control_byte[i] <= out_image[3*(i/2)+1][15:8];
                            chan_value[i] <= ord(out_image[3*(i/2)+2], big_endian);
                        end
                    end
                endcase
            end
        end
    end

    // Build the input image; status bytes take the control byte positions.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int w = 0; w < 8; w++) begin
                in_image[w] <= 16'h0000;
            end
        end else begin
            for (int w = 0; w < 8; w++) begin
                in_image[w] <= 16'h0000;
            end
            for (int i = 0; i < 4; i++) begin
                case (map_mode)
                    AOI_MAP_PLAIN: begin
                        in_image[i] <= ord(chan_value[i], big_endian);
                    end
                    AOI_MAP_FULL_ALIGNED: begin
                        in_image[2*i] <= {8'h00, channel_status_byte[i]};
                        in_image[2*i+1] <= ord(chan_value[i], big_endian);
                    end
                    default: begin
                        if (i[0] == 1'b0) begin
                            in_image[3*(i/2)] <= big_endian ?
                                {chan_value[i][15:8], channel_status_byte[i]} :
                                {chan_value[i][7:0], channel_status_byte[i]};
                            in_image[3*(i/2)+1][7:0] <= big_endian ? chan_value[i][7:0] : chan_value[i][15:8];
                        end else begin
                            in_image[3*(i/2)+1][15:8] <= channel_status_byte[i];
                            in_image[3*(i/2)+2] <= ord(chan_value[i], big_endian);
                        end
                    end
                endcase
            end
        end
    end

    // Converter code: the top bits of the value; scaling math is outside this block.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++) begin
                dac_code[i] <= 12'h000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                dac_code[i] <= chan_value[i][15:4];
            end
        end
    end

    // Protection lifts only on the exact key; each channel has its own lock.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            unlocked[i] = (unlock_r[i] == `AOI_UNLOCK_KEY);
        end
    end

    assign wr_param = reg_wr && unlocked[reg_chan];

    // Volatile alignment and code word registers.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++) begin
                align_r[i] <= `AOI_RST_ZERO;
                unlock_r[i] <= `AOI_RST_ZERO;
            end
        end else if (reg_wr) begin
            if (reg_addr == `AOI_ALIGN) begin
                align_r[reg_chan] <= reg_wdata;
            end else if (reg_addr == `AOI_UNLOCK) begin
                unlock_r[reg_chan] <= reg_wdata;
            end
        end
    end

    // Parameter bank, modelled as flip-flops standing in for the nonvolatile store.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++) begin
                hw_ver_r[i] <= `AOI_RST_ZERO;
                hw_ofs_r[i] <= `AOI_RST_ZERO;
                hw_gain_r[i] <= `AOI_RST_ZERO;
                f_ofs_r[i] <= `AOI_RST_ZERO;
                f_gain_r[i] <= `AOI_RST_F_GAIN;
                f_pon_r[i] <= `AOI_RST_ZERO;
                feature_r[i] <= `AOI_RST_FEATURE;
                u_ofs_r[i] <= `AOI_RST_ZERO;
                u_gain_r[i] <= `AOI_RST_U_GAIN;
                u_pon_r[i] <= `AOI_RST_ZERO;
            end
        end else if (wr_param) begin
            if (reg_addr == `AOI_HW_VER) begin
                hw_ver_r[reg_chan] <= reg_wdata;
            end else if (reg_addr == `AOI_HW_OFS) begin
                hw_ofs_r[reg_chan] <= {8'h00, reg_wdata[7:0]};
            end else if (reg_addr == `AOI_HW_GAIN) begin
                hw_gain_r[reg_chan] <= {8'h00, reg_wdata[7:0]};
            end else if (reg_addr == `AOI_F_OFS) begin
                f_ofs_r[reg_chan] <= reg_wdata;
            end else if (reg_addr == `AOI_F_GAIN) begin
                f_gain_r[reg_chan] <= reg_wdata;
            end else if (reg_addr == `AOI_F_PON) begin
                f_pon_r[reg_chan] <= reg_wdata;
            end else if (reg_addr == `AOI_FEATURE) begin
                feature_r[reg_chan] <= reg_wdata;
            end else if (reg_addr == `AOI_U_OFS) begin
                u_ofs_r[reg_chan] <= reg_wdata;
            end else if (reg_addr == `AOI_U_GAIN) begin
                u_gain_r[reg_chan] <= reg_wdata;
            end else if (reg_addr == `AOI_U_PON) begin
                u_pon_r[reg_chan] <= reg_wdata;
            end
        end
    end

    // Read decode; fixed registers have no storage so writes cannot reach them.
    always_comb begin
        if (reg_addr == `AOI_RAW_CODE) begin
            rdata_nxt = {4'h0, dac_code[reg_chan]};
        end else if (reg_addr == `AOI_DIAG || reg_addr == `AOI_CMD) begin
            rdata_nxt = `AOI_RST_ZERO;
        end else if (reg_addr == `AOI_TYPE_CODE) begin
            rdata_nxt = TYPE_CODE;
        end else if (reg_addr == `AOI_FW_VER) begin
            rdata_nxt = FW_VER;
        end else if (reg_addr == `AOI_SHIFT_LAYOUT) begin
            rdata_nxt = `AOI_RST_LAYOUT;
        end else if (reg_addr == `AOI_CHAN_COUNT) begin
            rdata_nxt = `AOI_RST_CHANS;
        end else if (reg_addr == `AOI_MIN_LEN) begin
            rdata_nxt = `AOI_RST_MINLEN;
        end else if (reg_addr == `AOI_DATA_STRUCT) begin
            rdata_nxt = `AOI_RST_STRUCT;
        end else if (reg_addr == `AOI_ALIGN) begin
            rdata_nxt = align_r[reg_chan];
        end else if (reg_addr == `AOI_HW_VER) begin
            rdata_nxt = hw_ver_r[reg_chan];
        end else if (reg_addr == `AOI_HW_OFS) begin
            rdata_nxt = hw_ofs_r[reg_chan];
        end else if (reg_addr == `AOI_HW_GAIN) begin
            rdata_nxt = hw_gain_r[reg_chan];
        end else if (reg_addr == `AOI_F_OFS) begin
            rdata_nxt = f_ofs_r[reg_chan];
        end else if (reg_addr == `AOI_F_GAIN) begin
            rdata_nxt = f_gain_r[reg_chan];
        end else if (reg_addr == `AOI_F_PON) begin
            rdata_nxt = f_pon_r[reg_chan];
        end else if (reg_addr == `AOI_UNLOCK) begin
            rdata_nxt = unlocked[reg_chan] ? unlock_r[reg_chan] : `AOI_RST_ZERO;
        end else if (reg_addr == `AOI_FEATURE) begin
            rdata_nxt = feature_r[reg_chan];
        end else if (reg_addr == `AOI_U_OFS) begin
            rdata_nxt = u_ofs_r[reg_chan];
        end else if (reg_addr == `AOI_U_GAIN) begin
            rdata_nxt = u_gain_r[reg_chan];
        end else if (reg_addr == `AOI_U_PON) begin
            rdata_nxt = u_pon_r[reg_chan];
        end else begin
            rdata_nxt = `AOI_RST_ZERO;
        end
    end

    // Registered read answer and a one-cycle acknowledge for both strobes.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= reg_rd || reg_wr;
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

    chk_locked_write: assert property (@(posedge clock) disable iff (!rstn)
        (reg_wr && !unlocked[reg_chan] && reg_addr == `AOI_F_GAIN)
        |=> (f_gain_r[$past(reg_chan)] == $past(f_gain_r[reg_chan])))
        else $error("factory gain changed while locked");

    chk_unlock_read: assert property (@(posedge clock) disable iff (!rstn)
        (reg_rd && reg_addr == `AOI_UNLOCK && !unlocked[reg_chan]) |=> (reg_rdata == 16'h0000))
        else $error("locked code word read not zero");

    chk_key_lifts: assert property (@(posedge clock) disable iff (!rstn)
        (reg_wr && reg_addr == `AOI_UNLOCK && reg_wdata == `AOI_UNLOCK_KEY) |=> unlocked[$past(reg_chan)])
        else $error("key did not lift protection");

    chk_fixed_type: assert property (@(posedge clock) disable iff (!rstn)
        (reg_rd && reg_addr == `AOI_TYPE_CODE) |=> (reg_rdata == TYPE_CODE))
        else $error("type code read wrong");

    chk_diag_zero: assert property (@(posedge clock) disable iff (!rstn)
        (reg_rd && (reg_addr == `AOI_DIAG || reg_addr == `AOI_CMD)) |=> (reg_rdata == 16'h0000))
        else $error("unused register not zero");

    chk_min_len: assert property (@(posedge clock) disable iff (!rstn)
        (reg_rd && reg_addr == `AOI_MIN_LEN) |=> (reg_rdata == 16'h9800))
        else $error("min length read wrong");

    chk_plain_map: assert property (@(posedge clock) disable iff (!rstn)
        (out_valid && !map_full && !big_endian) |=> (chan_value[1] == $past(out_image[1])))
        else $error("plain mapping wrong");

    chk_aligned_cb: assert property (@(posedge clock) disable iff (!rstn)
        (out_valid && map_full && map_aligned) |=> (channel_control_byte[3] == $past(out_image[6][7:0])))
        else $error("aligned control byte wrong");

    chk_raw_code: assert property (@(posedge clock) disable iff (!rstn)
        (reg_rd && reg_addr == `AOI_RAW_CODE) |=> (reg_rdata == {4'h0, $past(dac_code[reg_chan])}))
        else $error("raw code read does not match converter code");

endmodule

// ===== bench/aoi_coupler.sv
// Coupler-side model that packs four channel values and control bytes into the output image.
// Assumes the bench raises send for one cycle, just after a rising clock edge.
`timescale 1ns/1ns
module aoi_coupler (
    input  wire logic        clock,           // System clock.
    input  wire logic        map_full,        // Control bytes mapped.
    input  wire logic        map_aligned,     // One word pair per channel.
    input  wire logic        big_endian,      // Value bytes swapped for each channel, even across two words.
    input  wire logic        send,            // Start one image cycle.
    input  wire logic [15:0] val [0:3],       // Channel values to send.
    input  wire logic [7:0]  cb [0:3],        // Control bytes to send.
    output logic      [15:0] out_image [0:7], // Output image to the terminal.
    output logic             out_valid        // One-cycle image strobe.
);
    logic [15:0] img [0:7];
    logic [15:0] sw [0:3];
    logic        snd;

    // Build the image for the current mode; unused and reserved bytes carry junk on purpose.
    always_comb begin
        for (int i = 0; i < 8; i++) img[i] = val[0] ^ 16'ha5a5;
        for (int c = 0; c < 4; c++) begin
            sw[c] = big_endian ? {val[c][7:0], val[c][15:8]} : val[c];
            if (!map_full) img[c] = sw[c];
            else if (map_aligned) begin
                img[2*c]   = {~cb[c], cb[c]};
                img[2*c+1] = sw[c];
            end
        end
        if (map_full && !map_aligned) begin
            for (int p = 0; p < 2; p++) begin
                img[3*p]   = {big_endian ? val[2*p][15:8] : val[2*p][7:0], cb[2*p]};
                img[3*p+1] = {cb[2*p+1], big_endian ? val[2*p][7:0] : val[2*p][15:8]};
                img[3*p+2] = sw[2*p+1];
            end
        end
    end

    // Drive a fresh image with one strobe; between frames the words keep toggling.
    always @(posedge clock) begin
        snd = send;
        #1;
        out_valid = snd;
        for (int i = 0; i < 8; i++) out_image[i] = snd ? img[i] : ~out_image[i];
    end
endmodule

// ===== bench/aoi_regs_tb.sv
// Self-checking bench for the process image packer and the per-channel register bank.
// Assumes the design header and package are on the include path; inputs move 1 ns after an edge.
`timescale 1ns/1ns
`include "aoi_params.svh"
module aoi_regs_tb
    import aoi_pkg::*;
;
    localparam aoi_word_t TC = 16'h0c3d; // Arbitrary type value.
    localparam aoi_word_t FW = 16'h3230; // ASCII "2" then "0".
    logic        clock = 0, rstn = 0, map_full = 0, map_aligned = 0, big_endian = 0, send = 0;
    logic        reg_wr = 0, reg_rd = 0, out_valid, reg_ack;
    logic [15:0] val [0:3], out_image [0:7], in_image [0:7], chan_value [0:3];
    logic [7:0]  cb [0:3], channel_control_byte [0:3], channel_status_byte [0:3];
    logic [11:0] dac_code [0:3];
    logic [1:0]  reg_chan = 0;
    aoi_addr_t   reg_addr = 0;
    aoi_word_t   reg_wdata = 0, reg_rdata;
    logic [15:0] mdl [0:3][0:63];
    int          n_fail = 0, checks = 0, seed = 12;

    aoi_coupler cpl (.clock(clock), .map_full(map_full), .map_aligned(map_aligned), .big_endian(big_endian),
        .send(send), .val(val), .cb(cb), .out_image(out_image), .out_valid(out_valid));
    aoi_regs #(.CHANNELS(4), .TYPE_CODE(TC), .FW_VER(FW)) dut (.clock(clock), .rstn(rstn),
        .map_full(map_full), .map_aligned(map_aligned), .big_endian(big_endian), .out_image(out_image),
        .out_valid(out_valid), .in_image(in_image), .chan_value(chan_value),
        .channel_control_byte(channel_control_byte), .channel_status_byte(channel_status_byte),
        .dac_code(dac_code), .reg_chan(reg_chan), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));

    // Free-running 10 MHz clock.
    always #50 clock = ~clock;

    task automatic finish_test;
        if (n_fail == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic cmp_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_img(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // The code word register reads back only while it holds the unlock key.
    function automatic logic [15:0] mdl_read(input int ch, input int a);
        if (a == 6'h1f) return (mdl[ch][a] == `AOI_UNLOCK_KEY) ? mdl[ch][a] : 16'h0000;
        return mdl[ch][a];
    endfunction

    // Expected input image from the mapping rules; bytes that carry nothing read zero.
    function automatic logic [15:0] exp_in(input int w, input int m, input logic be);
        logic [15:0] v;
        int          c;
        if ((m == 0 && w > 3) || (m == 1 && w > 5)) return 16'h0000;
        c = (m == 2) ? w / 2 : (m == 1) ? (w / 3) * 2 : w;
        v = be ? {val[c][7:0], val[c][15:8]} : val[c];
        if (m == 0) return v;
        if (m == 2) return w[0] ? v : {8'h00, channel_status_byte[c]};
        case (w % 3)
            0: return {v[7:0], channel_status_byte[c]};
            1: return {channel_status_byte[c+1], v[15:8]};
            default: return be ? {val[c+1][7:0], val[c+1][15:8]} : val[c+1];
        endcase
        return 16'h0000;
    endfunction

    // Parameter writes land only on an unlocked channel; the trims keep their low byte.
    task automatic mdl_write(input int ch, input int a, input logic [15:0] d);
        logic unl;
        unl = (mdl[ch][6'h1f] == `AOI_UNLOCK_KEY);
        if (a == 6'h0f || a == 6'h1f) mdl[ch][a] = d;
        else if (unl && ((a >= 6'h10 && a <= 6'h15) || (a >= 6'h20 && a <= 6'h23)))
            mdl[ch][a] = (a == 6'h11 || a == 6'h12) ? {8'h00, d[7:0]} : d;
    endtask

    // One register cycle: strobe for one edge, then answer and acknowledge one cycle later.
    task automatic reg_op(input logic wr, input logic [1:0] ch, input aoi_addr_t a, input aoi_word_t d);
        @(posedge clock);
        #1;
        reg_chan = ch;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(posedge clock);
        #1;
        reg_wr = 0;
        reg_rd = 0;
        cmp_reg("reg_ack", 16'h0001, {15'h0000, reg_ack});
        if (!wr) cmp_reg("reg_rdata", mdl_read(ch, a), reg_rdata);
        else mdl_write(ch, a, d);
    endtask

    // Watchdog sized well past the roughly fourteen hundred cycles the tests take.
    initial begin
        #1000000;
        n_fail++;
        finish_test;
    end

    initial begin
        for (int c = 0; c < 4; c++) begin
            val[c] = 16'h0000;
            cb[c] = 8'h00;
            channel_status_byte[c] = 8'h00;
            for (int a = 0; a < 64; a++) mdl[c][a] = 16'h0000;
            mdl[c][8] = TC;
            mdl[c][9] = FW;
            mdl[c][6'h0a] = `AOI_RST_LAYOUT;
            mdl[c][6'h0b] = `AOI_RST_CHANS;
            mdl[c][6'h0c] = `AOI_RST_MINLEN;
            mdl[c][6'h14] = `AOI_RST_F_GAIN;
            mdl[c][6'h20] = `AOI_RST_FEATURE;
            mdl[c][6'h22] = `AOI_RST_U_GAIN;
        end
        repeat (12) @(posedge clock);
        #1;
        rstn = 1;
        // Every register of every channel at its reset value, reserved places included.
        for (int c = 0; c < 4; c++)
            for (int a = 0; a < 37; a++) reg_op(1'b0, 2'(c), 6'(a), 16'h0000);
        // Unlock channel 0 only; a near-miss key must leave the others protected.
        for (int c = 0; c < 4; c++) begin
            reg_op(1'b1, 2'(c), 6'h1f, (c == 0) ? `AOI_UNLOCK_KEY : 16'(`AOI_UNLOCK_KEY + c));
            reg_op(1'b1, 2'(c), 6'h14, 16'(16'h0005 + c));
            reg_op(1'b0, 2'(c), 6'h14, 16'h0000);
            reg_op(1'b0, 2'(c), 6'h1f, 16'h0000);
        end
        // Random traffic over the whole map, with the key offered often enough to matter.
        for (int i = 0; i < 500; i++) begin
            aoi_addr_t a;
            aoi_word_t d;
            a = ($random(seed) & 7) == 0 ? 6'h1f : aoi_addr_t'($random(seed));
            d = ($random(seed) & 3) == 0 ? `AOI_UNLOCK_KEY : aoi_word_t'($random(seed));
            reg_op(1'($random(seed)), 2'($random(seed)), a, d);
        end
        // Each mapping mode in both byte orders, then the raw converter code per channel.
        for (int m = 0; m < 3; m++)
            for (int e = 0; e < 2; e++) begin
                map_full = (m != 0);
                map_aligned = (m == 2);
                big_endian = e[0];
                for (int c = 0; c < 4; c++) begin
                    val[c] = 16'($random(seed));
                    cb[c] = 8'($random(seed));
                    channel_status_byte[c] = 8'($random(seed));
                end
                send = 1;
                @(posedge clock);
                #1;
                send = 0;
                repeat (3) @(posedge clock);
                #1;
                for (int c = 0; c < 4; c++) begin
                    cmp_img("chan_value", val[c], chan_value[c]);
                    cmp_img("control_byte", map_full ? cb[c] : 8'h00, channel_control_byte[c]);
                    cmp_img("dac_code", val[c][15:4], dac_code[c]);
                    if (m == 2) cmp_img("status", channel_status_byte[c], in_image[2*c][7:0]);
                    if (m == 1) cmp_img("status", channel_status_byte[c],
                        (c % 2) ? in_image[(c/2)*3+1][15:8] : in_image[(c/2)*3][7:0]);
                    mdl[c][5] = {4'h0, val[c][15:4]};
                end
                for (int w = 0; w < 8; w++) cmp_img("in_image", exp_in(w, m, big_endian), in_image[w]);
                for (int c = 0; c < 4; c++) reg_op(1'b0, 2'(c), 6'h05, 16'h0000);
            end
        finish_test;
    end
endmodule
